/* src/pco_pkg.sv */
/*
 * Shared constants of the programmable clock output block: register
 * addresses, field positions, reset values and select codes.
 * Assumes an 8-bit processor data bus with a 16-bit address.
 */
package pco_pkg;
    // ****************************************************************
    // Register addresses
    // ****************************************************************
    localparam logic [15:0] ADDR_CLKOUT_SEL = 16'hff40;
    localparam logic [15:0] ADDR_PORT14_DIR = 16'hff2e;
    localparam logic [15:0] ADDR_PORT14_LATCH = 16'hff0e;

    // ****************************************************************
    // Fields and reset values
    // ****************************************************************
    localparam int CLKOUT_ENABLE_BIT = 4;
    localparam int SRC_SEL_MSB = 3;
    localparam int CLKOUT_PIN_BIT = 0;
    localparam logic [4:0] CLKOUT_SEL_RESET = 5'h00;
    localparam logic [7:0] PORT14_DIR_RESET = 8'hff;
    localparam logic [7:0] PORT14_LATCH_RESET = 8'h00;
    localparam logic [7:0] READ_IDLE = 8'h00;

    // ****************************************************************
    // Source codes and divider width
    // ****************************************************************
    localparam logic [3:0] SRC_SUBSYSTEM = 4'h8;
    localparam int DIV_WIDTH = 7;
    localparam logic [6:0] DIV_ZERO = 7'h00;
    localparam logic [6:0] DIV_ONE = 7'h01;

    typedef enum {PCO_IDLE, PCO_RUN, PCO_DRAIN} pco_state_t;
endpackage : pco_pkg

/* src/pco_prescaler.sv */
/*
 * Free running binary prescaler for the clock output divider.
 * Assumes the caller clears it at the start of every output burst.
 */
`timescale 1ns/1ps
`default_nettype none
module pco_prescaler
    import pco_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic clear,
    output logic [DIV_WIDTH-1:0] count
);
    logic [DIV_WIDTH-1:0] countReg;
    logic [DIV_WIDTH-1:0] countNext;

    // ****************************************************************
    // Counter
    // ****************************************************************
    // Restart from zero on clear, else count every cycle
    always_comb begin
        countNext = clear ? DIV_ZERO : countReg + DIV_ONE;
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            countReg <= DIV_ZERO;
        end else begin
            countReg <= countNext;
        end
    end

    assign count = countReg;
endmodule : pco_prescaler
`default_nettype wire

/* src/pco_clock_output.sv */
/*
 * Programmable clock output: selection register, port 14 direction and
 * latch registers, glitch free divider and pin driver.
 * Assumes the peripheral clock equals mclk/2 and the subsystem clock
 * arrives as a slow level on subClk, synchronised here.
 */
// How it works
// R1: Enable clear stops the divider and holds the output low.
// R2: Enable set runs the divider and drives the chosen clock.
// R3: Codes 0 to 7 select peripheral clock divided by two to the n.
// R4: Code 1000 passes the subsystem clock; higher codes are never written.
// R5: Software keeps the output at or below 10 MHz.
// R6: Software changes the source only while output is stopped.
// R7: Software programs the source first, then sets enable.
// R8: Output starts inside a low phase, so no short pulses appear.
// R9: Output stops only after the current high phase has completed.
// R10: Enable sits at bit 4, source select at bits 3 to 0.
// R11: Reset clears the selection register, output disabled and low.
// R12: Selection register takes single bit and whole byte writes.
// R13: Software clears direction and latch bits to use the clock pin.
// R14: Direction bit 0 turns the pin buffer on, 1 makes it input.
// R15: Reset sets every port 14 direction bit to one.
// R16: Divided clocks come from a binary counter, giving square waves.
`timescale 1ns/1ps
`default_nettype none
module pco_clock_output
    import pco_pkg::*;
(
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic [15:0] busAddr,
    input wire logic busWrite,
    input wire logic [7:0] busWrData,
    input wire logic busBitOp,
    input wire logic [2:0] busBitIdx,
    input wire logic busBitVal,
    input wire logic busRead,
    output logic [7:0] busRdData,
    input wire logic subClk,
    output logic clkoutPin,
    output logic clkoutPinOe
);
    typedef struct packed {
        logic [4:0] sel;
        logic [7:0] dir;
        logic [7:0] latch;
        logic [7:0] rdData;
        logic level;
        logic subMeta;
        logic subSync;
        logic pinOut;
        logic pinOe;
    } pco_regs_t;

    pco_regs_t s_reg;
    pco_regs_t s_next;
    pco_state_t st_reg;
    pco_state_t st_next;
    logic [DIV_WIDTH-1:0] divCount;
    logic divClear;

    // ****************************************************************
    // Helpers
    // ****************************************************************
    // Terminal count mask for a select code: 2^n - 1
    function automatic logic [DIV_WIDTH-1:0] pco_mask(input logic [3:0] code);
        pco_mask = DIV_WIDTH'((8'h01 << code[2:0]) - 8'h01);
    endfunction : pco_mask

    // Byte after a bit manipulation or a whole byte write
    function automatic logic [7:0] pco_merge(input logic [7:0] old, input logic bitOp,
                                             input logic [2:0] idx, input logic val,
                                             input logic [7:0] data);
        logic [7:0] r;
        r = bitOp ? old : data;
        if (bitOp) begin
            r[idx] = val;
        end
        pco_merge = r;
    endfunction : pco_merge

    pco_prescaler u_prescaler (
        .mclk(mclk),
        .rst_b(rst_b),
        .clear(divClear),
        .count(divCount)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        logic [7:0] selByte;
        logic [7:0] selMerged;
        logic enable;
        logic isSub;
        logic tick;
        logic lvl;
        logic wr;
        selByte = {3'h0, s_reg.sel};
        selMerged = selByte;
        enable = 1'b0;
        isSub = 1'b0;
        tick = 1'b0;
        lvl = 1'b0;
        s_next = s_reg;
        st_next = st_reg;
        divClear = 1'b0;
        wr = busWrite | busBitOp;
        // Register writes, bits 7..5 of the selection register stay zero
        if (wr && busAddr == ADDR_CLKOUT_SEL) begin
            selMerged = pco_merge(selByte, busBitOp, busBitIdx, busBitVal, busWrData); // [R12]
            s_next.sel = selMerged[CLKOUT_ENABLE_BIT:0]; // [R10]
        end else if (wr && busAddr == ADDR_PORT14_DIR) begin
            s_next.dir = pco_merge(s_reg.dir, busBitOp, busBitIdx, busBitVal, busWrData);
        end else if (wr && busAddr == ADDR_PORT14_LATCH) begin
            s_next.latch = pco_merge(s_reg.latch, busBitOp, busBitIdx, busBitVal, busWrData);
        end
        // Registered read data, unmapped reads give zero
        if (!busRead) begin
            s_next.rdData = READ_IDLE;
        end else if (busAddr == ADDR_CLKOUT_SEL) begin
            s_next.rdData = selByte;
        end else if (busAddr == ADDR_PORT14_DIR) begin
            s_next.rdData = s_reg.dir;
        end else if (busAddr == ADDR_PORT14_LATCH) begin
            s_next.rdData = s_reg.latch;
        end else begin
            s_next.rdData = READ_IDLE;
        end
        // Subsystem clock synchroniser
        s_next.subMeta = subClk;
        s_next.subSync = s_reg.subMeta;
        enable = s_reg.sel[CLKOUT_ENABLE_BIT];
        isSub = s_reg.sel[SRC_SEL_MSB:0] == SRC_SUBSYSTEM;
        tick = (divCount & pco_mask(s_reg.sel[SRC_SEL_MSB:0])) == pco_mask(s_reg.sel[SRC_SEL_MSB:0]); // [R16]
        // Advance the output level when running
        if (isSub) begin
            lvl = s_reg.subSync; // [R4]
        end else if (s_reg.sel[SRC_SEL_MSB]) begin
            lvl = 1'b0;
        end else begin
            lvl = tick ? ~s_reg.level : s_reg.level; // [R3] [R16]
        end
        case (st_reg)
            PCO_IDLE: begin
                s_next.level = 1'b0; // [R1]
                if (enable && (!isSub || !s_reg.subSync)) begin
                    divClear = 1'b1; // [R8]
                    st_next = PCO_RUN; // [R2]
                end
            end
            PCO_RUN: begin
                if (!enable && !s_reg.level) begin
                    s_next.level = 1'b0;
                    st_next = PCO_IDLE; // [R1]
                end else if (!enable) begin
                    s_next.level = lvl;
                    st_next = lvl ? PCO_DRAIN : PCO_IDLE; // [R9]
                end else begin
                    s_next.level = lvl; // [R2]
                end
            end
            default: begin
                s_next.level = lvl;
                if (!lvl) begin
                    st_next = enable ? PCO_RUN : PCO_IDLE; // [R9]
                end
            end
        endcase
        // Pin driver: the latch bit is ORed in, so it must be zero for clock use
        s_next.pinOut = s_next.level | s_reg.latch[CLKOUT_PIN_BIT];
        s_next.pinOe = ~s_reg.dir[CLKOUT_PIN_BIT]; // [R14]
    end

    // ****************************************************************
    // State registers
    // ****************************************************************
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            s_reg.sel <= CLKOUT_SEL_RESET; // [R11]
            s_reg.dir <= PORT14_DIR_RESET; // [R15]
            s_reg.latch <= PORT14_LATCH_RESET;
            s_reg.rdData <= READ_IDLE;
            s_reg.level <= 1'b0;
            s_reg.subMeta <= 1'b0;
            s_reg.subSync <= 1'b0;
            s_reg.pinOut <= 1'b0;
            s_reg.pinOe <= 1'b0;
            st_reg <= PCO_IDLE;
        end else begin
            s_reg <= s_next;
            st_reg <= st_next;
        end
    end

    assign busRdData = s_reg.rdData;
    assign clkoutPin = s_reg.pinOut;
    assign clkoutPinOe = s_reg.pinOe;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    off_low_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R1]
        st_reg == PCO_IDLE |-> !s_reg.level) else $error("level high while idle");
    start_low_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R8]
        (st_reg == PCO_IDLE && st_next == PCO_RUN && s_reg.sel[SRC_SEL_MSB:0] != SRC_SUBSYSTEM
         && s_reg.sel[SRC_SEL_MSB:0] != 4'h0)
        |=> !s_reg.level [*2]) else $error("output did not start in low phase");
    half_period_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R3]
        (st_reg == PCO_RUN && s_reg.sel == 5'h12 && $rose(s_reg.level))
        |-> s_reg.level [*4] ##1 !s_reg.level) else $error("divide by 4 high phase wrong");
    drain_high_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R9]
        st_reg == PCO_DRAIN |-> s_reg.level) else $error("drain entered with low level");
    stop_now_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R1]
        (st_reg == PCO_RUN && !s_reg.sel[CLKOUT_ENABLE_BIT] && !s_reg.level)
        |=> st_reg == PCO_IDLE) else $error("disabled output kept running");
    pin_dir_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R14]
        1'b1 |=> clkoutPinOe == !$past(s_reg.dir[CLKOUT_PIN_BIT])) else $error("pin buffer mismatches direction");
    bit_write_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R12]
        (busBitOp && busAddr == ADDR_CLKOUT_SEL && busBitIdx == 3'h4)
        |=> s_reg.sel[CLKOUT_ENABLE_BIT] == $past(busBitVal)) else $error("bit write to enable lost");
    byte_write_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R10]
        (busWrite && !busBitOp && busAddr == ADDR_CLKOUT_SEL)
        |=> s_reg.sel == $past(busWrData[4:0])) else $error("byte write to select lost");
    sub_route_a: assert property (@(posedge mclk) disable iff (!rst_b) // [R4]
        (st_reg == PCO_RUN && s_reg.sel == 5'h18)
        |=> s_reg.level == $past(s_reg.subSync)) else $error("subsystem clock not routed");
endmodule : pco_clock_output
`default_nettype wire

/* bench/pco_clock_sink.sv */
/* Partner model: an external chip clocked from the clock output pin.
   Assumes pin value and enable from the design, sampled on mclk. */
`timescale 1ns/1ps
`default_nettype none
module pco_clock_sink (
    input wire logic mclk,
    input wire logic clearStats,
    input wire logic pinDrive,
    input wire logic pinOe,
    output logic [8:0] highWidth,
    output logic [8:0] lowWidth,
    output logic [8:0] minHigh,
    output int riseCount
);
    logic lastLevel = 1'b0;
    logic lastDriven = 1'b0;
    logic [8:0] runLen = 9'h001;
    // Released line has no pull, so it shows the inverse of the last driven level
    wire logic lineLevel = pinOe ? pinDrive : ~lastDriven;

    // Measure high and low phase widths in mclk cycles
    always @(posedge mclk) begin
        lastLevel <= lineLevel;
        if (pinOe) begin
            lastDriven <= pinDrive;
        end
        if (clearStats) begin
            riseCount <= 0;
            minHigh <= 9'h1ff;
            runLen <= 9'h001;
        end else if (lineLevel != lastLevel) begin
            if (lineLevel) begin
                riseCount <= riseCount + 1;
                lowWidth <= runLen;
            end else begin
                highWidth <= runLen;
                if (runLen < minHigh) begin
                    minHigh <= runLen;
                end
            end
            runLen <= 9'h001;
        end else begin
            runLen <= runLen + 9'h001;
        end
    end
endmodule : pco_clock_sink
`default_nettype wire

/* bench/test_programmable_clock_output.sv */
/* Testbench of the clock output block: registers, divider, subsystem path.
   Assumes pco_pkg, the design and pco_clock_sink compiled before it. */
`timescale 1ns/1ps
`default_nettype none
module test_programmable_clock_output import pco_pkg::*;;
    localparam int SUB_HALF = 40;
    logic mclk = 1'b0;
    logic rstB = 1'b0;
    logic [15:0] busAddr = 16'h0000;
    logic busWrite = 1'b0;
    logic [7:0] busWrData = 8'h00;
    logic busBitOp = 1'b0;
    logic [2:0] busBitIdx = 3'h0;
    logic busBitVal = 1'b0;
    logic busRead = 1'b0;
    logic [7:0] busRdData;
    logic subClk = 1'b0;
    logic subRun = 1'b0;
    logic [5:0] subCnt = 6'h00;
    logic clkoutPin;
    logic clkoutPinOe;
    logic clearStats = 1'b0;
    logic [8:0] highWidth;
    logic [8:0] lowWidth;
    logic [8:0] minHigh;
    int riseCount;
    int nMismatch = 0;
    int checkCount = 0;
    logic [7:0] rdVal;

    // ****************************************************************
    // Clock, subsystem clock, design and partner
    // ****************************************************************
    always #10 mclk = ~mclk;

    // Slow subsystem clock, half period SUB_HALF mclk cycles
    always @(posedge mclk) begin
        if (!subRun) begin
            subCnt <= 6'h00;
            subClk <= 1'b0;
        end else if (subCnt == 6'(SUB_HALF - 1)) begin
            subCnt <= 6'h00;
            subClk <= ~subClk;
        end else begin
            subCnt <= subCnt + 6'h01;
        end
    end

    pco_clock_output pco_clock_output_inst (.mclk(mclk), .rst_b(rstB), .busAddr(busAddr), .busWrite(busWrite),
        .busWrData(busWrData), .busBitOp(busBitOp), .busBitIdx(busBitIdx), .busBitVal(busBitVal),
        .busRead(busRead), .busRdData(busRdData), .subClk(subClk), .clkoutPin(clkoutPin),
        .clkoutPinOe(clkoutPinOe));
    pco_clock_sink pco_clock_sink_inst (.mclk(mclk), .clearStats(clearStats), .pinDrive(clkoutPin),
        .pinOe(clkoutPinOe), .highWidth(highWidth), .lowWidth(lowWidth), .minHigh(minHigh),
        .riseCount(riseCount));

    task automatic check(input logic [8:0] seen, input logic [8:0] expected, input string what);
        checkCount++;
        if (seen !== expected) begin
            nMismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, expected);
        end
    endtask : check

    task automatic report_and_stop();
        if (nMismatch == 0 && checkCount > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : report_and_stop

    // Bus cycles: strobe for one cycle, taken at the following edge
    task automatic wr_byte(input logic [15:0] addr, input logic [7:0] data);
        @(posedge mclk);
        busAddr <= addr;
        busWrData <= data;
        busWrite <= 1'b1;
        @(posedge mclk);
        busWrite <= 1'b0;
    endtask : wr_byte

    task automatic wr_bit(input logic [15:0] addr, input logic [2:0] idx, input logic val);
        @(posedge mclk);
        busAddr <= addr;
        busBitIdx <= idx;
        busBitVal <= val;
        busBitOp <= 1'b1;
        @(posedge mclk);
        busBitOp <= 1'b0;
    endtask : wr_bit

    task automatic rd(input logic [15:0] addr, input logic [7:0] expected);
        @(posedge mclk);
        busAddr <= addr;
        busRead <= 1'b1;
        @(posedge mclk);
        busRead <= 1'b0;
        #1 rdVal = busRdData;
        check({1'b0, rdVal}, {1'b0, expected}, "read data");
    endtask : rd

    task automatic wait_rises(input int n);
        int k;
        k = 0;
        while (riseCount < n && k < 2000) begin
            @(posedge mclk);
            k++;
        end
        check({8'h00, riseCount >= n}, 9'h001, "rising edges seen");
    endtask : wait_rises

    // Divide by 2^n, then stop while the pin is high
    task automatic test_divider(input int n);
        int k;
        wr_byte(ADDR_CLKOUT_SEL, {4'h0, 4'(n)});
        clearStats <= 1'b1;
        @(posedge mclk);
        clearStats <= 1'b0;
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b1);
        wait_rises(3);
        check(highWidth, 9'(1 << n), "high width");
        check(lowWidth, 9'(1 << n), "low width");
        check(minHigh, 9'(1 << n), "first pulse");
        k = 0;
        while (clkoutPin !== 1'b1 && k < 300) begin
            @(posedge mclk);
            k++;
        end
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b0);
        repeat ((1 << n) + 4) @(posedge mclk);
        #1 check({8'h00, clkoutPin}, 9'h000, "pin after stop");
        k = riseCount;
        repeat ((2 << n) + 4) @(posedge mclk);
        check(9'(riseCount - k), 9'h000, "edges after stop");
        check(highWidth, 9'(1 << n), "last high width");
        check(minHigh, 9'(1 << n), "shortest high");
    endtask : test_divider

    initial begin
        repeat (16) @(posedge mclk);
        rstB <= 1'b1;
        #1 check({7'h00, clkoutPin, clkoutPinOe}, 9'h000, "pin at reset");
        rd(ADDR_CLKOUT_SEL, 8'h00);
        rd(ADDR_PORT14_DIR, 8'hff);
        wr_byte(ADDR_CLKOUT_SEL, 8'he5);
        rd(ADDR_CLKOUT_SEL, 8'h05);
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b1);
        rd(ADDR_CLKOUT_SEL, 8'h15);
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b0);
        rd(ADDR_CLKOUT_SEL, 8'h05);
        rd(16'hff41, 8'h00);
        wr_byte(ADDR_PORT14_LATCH, 8'h00);
        rd(ADDR_PORT14_LATCH, 8'h00);
        wr_bit(ADDR_PORT14_DIR, 3'h0, 1'b0);
        // Buffer enable is registered from the direction bit one cycle later
        @(posedge mclk);
        #1 check({8'h00, clkoutPinOe}, 9'h001, "buffer on");
        for (int n = 2; n < 8; n++) begin
            test_divider(n);
        end
        // Subsystem clock passes through unchanged
        wr_byte(ADDR_CLKOUT_SEL, {4'h0, SRC_SUBSYSTEM});
        subRun <= 1'b1;
        clearStats <= 1'b1;
        @(posedge mclk);
        clearStats <= 1'b0;
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b1);
        wait_rises(3);
        check(highWidth, 9'(SUB_HALF), "sub high width");
        check(lowWidth, 9'(SUB_HALF), "sub low width");
        wr_bit(ADDR_CLKOUT_SEL, 3'h4, 1'b0);
        repeat (2 * SUB_HALF + 8) @(posedge mclk);
        #1 check({8'h00, clkoutPin}, 9'h000, "sub pin after stop");
        wr_bit(ADDR_PORT14_DIR, 3'h0, 1'b1);
        @(posedge mclk);
        #1 check({8'h00, clkoutPinOe}, 9'h000, "buffer off");
        report_and_stop();
    end

    // Watchdog well beyond the longest expected run
    initial begin
        repeat (20000) @(posedge mclk);
        nMismatch++;
        report_and_stop();
    end
endmodule : test_programmable_clock_output
`default_nettype wire
